// ===== hw/cie_pkg.sv
// shared constants and types for the instruction execution subset
package cie_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int FILE_ADDR_W    = 7;
	localparam int DATA_W         = 8;
	localparam int PC_W           = 13;
	localparam int LIT_W          = 11;
	localparam int BIT_SEL_W      = 3;
	localparam int STACK_DEPTH    = 8;
	localparam int STACK_PTR_W    = 3;
	localparam int BUS_ADDR_W     = 8;
	localparam int PAGE_W         = 5;
	localparam int WDOG_PRESC_W   = 8;
	localparam int WDOG_COUNT_W   = 8;

	// ****************************************
	// bus offsets, addresses below 8'h80 reach the file registers
	// ****************************************
	localparam int                    FILE_SPACE_BIT = 7;
	localparam logic [BUS_ADDR_W-1:0] OFS_ACCUM      = 8'h80;
	localparam logic [BUS_ADDR_W-1:0] OFS_STATUS     = 8'h81;
	localparam logic [BUS_ADDR_W-1:0] OFS_PC_LO      = 8'h82;
	localparam logic [BUS_ADDR_W-1:0] OFS_PC_HI      = 8'h83;
	localparam logic [BUS_ADDR_W-1:0] OFS_WDOG       = 8'h84;
	localparam logic [BUS_ADDR_W-1:0] OFS_PAGE       = 8'h85;
	localparam logic [BUS_ADDR_W-1:0] OFS_STACK_LO   = 8'h86;
	localparam logic [BUS_ADDR_W-1:0] OFS_STACK_HI   = 8'h87;

	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int STAT_ZERO_BIT   = 0;
	localparam int STAT_SLEEP_BIT  = 1;
	localparam int STAT_EXPIRY_BIT = 2;
	localparam int PAGE_SEL_HI     = 4;
	localparam int PAGE_SEL_LO     = 3;
	localparam logic [DATA_W-1:0]       ZERO_BYTE  = 8'h00;
	localparam logic [DATA_W-1:0]       ONE_BYTE   = 8'h01;
	localparam logic [PC_W-1:0]         PC_RESET   = 13'h0000;
	localparam logic [PC_W-1:0]         PC_ONE     = 13'h0001;
	localparam logic [PAGE_W-1:0]       PAGE_RESET = 5'h00;
	localparam logic [STACK_PTR_W-1:0]  PTR_ONE    = 3'h1;
	localparam logic [WDOG_PRESC_W-1:0] PRESC_MAX  = 8'hFF;
	localparam logic [WDOG_PRESC_W-1:0] PRESC_ONE  = 8'h01;
	localparam logic [WDOG_COUNT_W-1:0] WDOG_MAX   = 8'hFF;
	localparam logic                    DEST_ACCUM = 1'b0;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		OP_NOP                  = 3'h0,
		OP_BIT_TEST_SKIP_IF_SET = 3'h1,
		OP_WATCHDOG_CLEAR       = 3'h2,
		OP_CALL                 = 3'h3,
		OP_COMPLEMENT_REG       = 3'h4,
		OP_CLEAR_REG            = 3'h5,
		OP_DECREMENT_REG        = 3'h6,
		OP_CLEAR_ACCUMULATOR    = 3'h7
	} cie_opcode_type;

	typedef struct packed {
		cie_opcode_type         opcode;
		logic [FILE_ADDR_W-1:0] fileAddr;
		logic [BIT_SEL_W-1:0]   bitSel;
		logic                   dest;
		logic [LIT_W-1:0]       literal;
	} cie_instr_type;

	typedef struct packed {
		logic                  write;
		logic                  read;
		logic [BUS_ADDR_W-1:0] addr;
		logic [DATA_W-1:0]     data;
	} cie_bus_req_type;

	typedef enum logic [2:0] {
		ST_ACCEPT  = 3'h1,
		ST_EXECUTE = 3'h2,
		ST_NOP     = 3'h4
	} cie_state_type;

endpackage

// ===== hw/cie_regfile.sv
// file register memory, one write port and two registered read ports
`timescale 1ns/100ps
module cie_regfile
	import cie_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   writeEnable,
	input  wire logic [FILE_ADDR_W-1:0] writeAddr,
	input  wire logic [DATA_W-1:0]      writeData,
	input  wire logic                   readEnableA,
	input  wire logic [FILE_ADDR_W-1:0] readAddrA,
	output logic      [DATA_W-1:0]      readDataA,
	input  wire logic                   readEnableB,
	input  wire logic [FILE_ADDR_W-1:0] readAddrB,
	output logic      [DATA_W-1:0]      readDataB
);

	logic [DATA_W-1:0] cells [2**FILE_ADDR_W];

	// read data hold until the next read, the executing stage relies on it
	always_ff @(posedge sys_clk) begin
		if (writeEnable) begin
			cells[writeAddr] <= writeData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (readEnableA) begin
			readDataA <= cells[readAddrA];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (readEnableB) begin
			readDataB <= cells[readAddrB];
		end
	end

endmodule

// ===== hw/cie_core.sv
// execution of a subset of the core instructions
//
// Summary of operation
// - skip-if-set discards next instruction when bit is 1
// - skip-if-set leaves all status flags unchanged
// - watchdog clear zeroes counter and prescaler
// - watchdog clear sets expiry and sleep bits
// - call pushes program counter plus one
// - call loads literal and page latch bits
// - call takes two cycles, flags untouched
// - complement inverts, sets zero flag, selects destination
// - clear register writes zero, sets zero flag
// - decrement subtracts one, sets zero flag, selects destination
// - clear accumulator writes zero, sets zero flag
// - counter change or true test adds NOP cycle
`timescale 1ns/100ps
module cie_core
	import cie_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	input  wire cie_instr_type         instr,
	input  wire logic                  instrValid,
	output logic                       instrReady,
	output logic                       instrDone,
	output logic                       nopCycle,
	input  wire logic                  sleepEnter,
	input  wire logic [BUS_ADDR_W-1:0] busAddr,
	input  wire logic [DATA_W-1:0]     busWriteData,
	input  wire logic                  busWrite,
	input  wire logic                  busRead,
	output logic      [DATA_W-1:0]     busReadData,
	output logic      [PC_W-1:0]       programCounter,
	output logic      [DATA_W-1:0]     accumulator,
	output logic                       zeroFlag,
	output logic                       expiryStatus,
	output logic                       sleepStatus,
	output logic      [WDOG_COUNT_W-1:0] watchdogCount,
	output logic      [PC_W-1:0]       stackTop
);

	// ****************************************
	// declarations
	// ****************************************
	cie_state_type          state;
	cie_state_type          next_state;
	cie_instr_type          held;
	cie_bus_req_type        bus;
	logic                   accept;
	logic                   executing;
	logic                   execActive;
	logic                   busConflict;
	logic                   writesFile;
	logic                   writesAccum;
	logic                   touchesZero;
	logic [DATA_W-1:0]      fileData;
	logic [DATA_W-1:0]      result;
	logic                   resultZero;
	logic                   bitSet;
	logic                   skipNext;
	logic                   twoCycle;
	logic                   nopSkips;
	logic [PC_W-1:0]        pcPlusOne;
	logic [PC_W-1:0]        stackMem [STACK_DEPTH];
	logic [STACK_PTR_W-1:0] stackPtr;
	logic                   pushStack;
	logic [PAGE_W-1:0]      pageLatch;
	logic [WDOG_PRESC_W-1:0] prescaler;
	logic                   watchdogClear;
	logic                   prescWrap;
	logic                   timeoutEvent;
	logic                   memWriteEnable;
	logic [FILE_ADDR_W-1:0] memWriteAddr;
	logic [DATA_W-1:0]      memWriteData;
	logic                   fileWriteByBus;
	logic                   fileReadByBus;
	logic [DATA_W-1:0]      memBusData;
	logic                   readPending;
	logic                   readFromFile;
	logic [DATA_W-1:0]      regReadData;
	logic [DATA_W-1:0]      next_regReadData;
	logic [DATA_W-1:0]      statusByte;

	assign bus.write = busWrite;
	assign bus.read  = busRead;
	assign bus.addr  = busAddr;
	assign bus.data  = busWriteData;

	// ****************************************
	// sequencing
	// ****************************************
	assign instrReady = (state == ST_ACCEPT);
	assign accept     = instrReady && instrValid;
	assign executing  = (state == ST_EXECUTE);
	assign nopCycle   = (state == ST_NOP);

	// a bus write to something the instruction also writes wins,
	// the instruction then retires one cycle later with no loss
	assign busConflict = executing && bus.write && (
		(writesFile && !bus.addr[FILE_SPACE_BIT]) ||
		(writesAccum && bus.addr == OFS_ACCUM) ||
		(touchesZero && bus.addr == OFS_STATUS));
	assign execActive = executing && !busConflict;

	assign twoCycle = (held.opcode == OP_CALL) || skipNext;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_ACCEPT: begin
				if (accept) begin
					next_state = ST_EXECUTE;
				end
			end
			ST_EXECUTE: begin
				if (execActive) begin
					next_state = twoCycle ? ST_NOP : ST_ACCEPT;
				end
			end
			ST_NOP: begin
				next_state = ST_ACCEPT;
			end
			default: begin
				next_state = ST_ACCEPT;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state <= ST_ACCEPT;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			held <= '0;
		end else if (accept) begin
			held <= instr;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			nopSkips <= 1'b0;
		end else if (execActive) begin
			nopSkips <= skipNext;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			instrDone <= 1'b0;
		end else begin
			instrDone <= (execActive && !twoCycle) || nopCycle;
		end
	end

	// ****************************************
	// data path
	// ****************************************
	assign bitSet   = fileData[held.bitSel];
	assign skipNext = (held.opcode == OP_BIT_TEST_SKIP_IF_SET) && bitSet;

	always_comb begin
		result      = ZERO_BYTE;
		writesFile  = 1'b0;
		writesAccum = 1'b0;
		touchesZero = 1'b0;
		unique case (held.opcode)
			OP_COMPLEMENT_REG: begin
				result      = ~fileData;
				writesFile  = (held.dest != DEST_ACCUM);
				writesAccum = (held.dest == DEST_ACCUM);
				touchesZero = 1'b1;
			end
			OP_DECREMENT_REG: begin
				result      = fileData - ONE_BYTE;
				writesFile  = (held.dest != DEST_ACCUM);
				writesAccum = (held.dest == DEST_ACCUM);
				touchesZero = 1'b1;
			end
			OP_CLEAR_REG: begin
				result      = ZERO_BYTE;
				writesFile  = 1'b1;
				touchesZero = 1'b1;
			end
			OP_CLEAR_ACCUMULATOR: begin
				result      = ZERO_BYTE;
				writesAccum = 1'b1;
				touchesZero = 1'b1;
			end
			// skip test, call and watchdog clear leave the zero flag alone
			OP_BIT_TEST_SKIP_IF_SET, OP_CALL, OP_WATCHDOG_CLEAR, OP_NOP: begin
				result = ZERO_BYTE;
			end
		endcase
	end

	assign resultZero = (result == ZERO_BYTE);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			accumulator <= ZERO_BYTE;
		end else if (execActive && writesAccum) begin
			accumulator <= result;
		end else if (bus.write && bus.addr == OFS_ACCUM) begin
			accumulator <= bus.data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			zeroFlag <= 1'b0;
		end else if (execActive && touchesZero) begin
			zeroFlag <= resultZero;
		end else if (bus.write && bus.addr == OFS_STATUS) begin
			zeroFlag <= bus.data[STAT_ZERO_BIT];
		end
	end

	// ****************************************
	// file registers
	// ****************************************
	assign fileWriteByBus = bus.write && !bus.addr[FILE_SPACE_BIT];
	assign fileReadByBus  = bus.read && !bus.addr[FILE_SPACE_BIT];
	assign memWriteEnable = (execActive && writesFile) || fileWriteByBus;
	assign memWriteAddr   = (execActive && writesFile) ? held.fileAddr
	                                                   : bus.addr[FILE_ADDR_W-1:0];
	assign memWriteData   = (execActive && writesFile) ? result : bus.data;

	cie_regfile u_regfile (
		.sys_clk     (sys_clk),
		.writeEnable (memWriteEnable),
		.writeAddr   (memWriteAddr),
		.writeData   (memWriteData),
		.readEnableA (accept),
		.readAddrA   (instr.fileAddr),
		.readDataA   (fileData),
		.readEnableB (fileReadByBus),
		.readAddrB   (bus.addr[FILE_ADDR_W-1:0]),
		.readDataB   (memBusData)
	);

	// ****************************************
	// program counter and return stack
	// ****************************************
	assign pcPlusOne = programCounter + PC_ONE;
	assign pushStack = execActive && (held.opcode == OP_CALL);

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			programCounter <= PC_RESET;
		end else if (execActive && held.opcode == OP_CALL) begin
			programCounter <= {pageLatch[PAGE_SEL_HI:PAGE_SEL_LO], held.literal};
		end else if (execActive) begin
			programCounter <= pcPlusOne;
		end else if (nopCycle && nopSkips) begin
			programCounter <= pcPlusOne;
		end
	end

	// the stack wraps silently, a ninth call overwrites the oldest entry
	generate
		for (genvar e = 0; e < STACK_DEPTH; e++) begin : g_stack
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					stackMem[e] <= PC_RESET;
				end else if (pushStack && stackPtr == STACK_PTR_W'(e)) begin
					stackMem[e] <= pcPlusOne;
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			stackPtr <= '0;
		end else if (pushStack) begin
			stackPtr <= stackPtr + PTR_ONE;
		end
	end

	assign stackTop = stackMem[stackPtr - PTR_ONE];

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pageLatch <= PAGE_RESET;
		end else if (bus.write && bus.addr == OFS_PAGE) begin
			pageLatch <= bus.data[PAGE_W-1:0];
		end
	end

	// ****************************************
	// watchdog
	// ****************************************
	assign watchdogClear = execActive && (held.opcode == OP_WATCHDOG_CLEAR);
	assign prescWrap     = (prescaler == PRESC_MAX);
	assign timeoutEvent  = prescWrap && (watchdogCount == WDOG_MAX) && !watchdogClear;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prescaler <= '0;
		end else if (watchdogClear) begin
			prescaler <= '0;
		end else begin
			prescaler <= prescaler + PRESC_ONE;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			watchdogCount <= '0;
		end else if (watchdogClear) begin
			watchdogCount <= '0;
		end else if (prescWrap) begin
			watchdogCount <= watchdogCount + PRESC_ONE;
		end
	end

	// expiry bit low after a timeout, only an instruction clear or a reset restores it
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			expiryStatus <= 1'b1;
		end else if (timeoutEvent) begin
			expiryStatus <= 1'b0;
		end else if (watchdogClear) begin
			expiryStatus <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sleepStatus <= 1'b1;
		end else if (watchdogClear) begin
			sleepStatus <= 1'b1;
		end else if (sleepEnter) begin
			sleepStatus <= 1'b0;
		end
	end

	// ****************************************
	// register port
	// ****************************************
	assign statusByte = {5'h00, expiryStatus, sleepStatus, zeroFlag};

	always_comb begin
		next_regReadData = ZERO_BYTE;
		unique case (bus.addr)
			OFS_ACCUM:    next_regReadData = accumulator;
			OFS_STATUS:   next_regReadData = statusByte;
			OFS_PC_LO:    next_regReadData = programCounter[7:0];
			OFS_PC_HI:    next_regReadData = {3'h0, programCounter[PC_W-1:8]};
			OFS_WDOG:     next_regReadData = watchdogCount;
			OFS_PAGE:     next_regReadData = {3'h0, pageLatch};
			OFS_STACK_LO: next_regReadData = stackTop[7:0];
			OFS_STACK_HI: next_regReadData = {3'h0, stackTop[PC_W-1:8]};
			default:      next_regReadData = ZERO_BYTE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			readPending  <= 1'b0;
			readFromFile <= 1'b0;
			regReadData  <= ZERO_BYTE;
		end else begin
			readPending  <= bus.read;
			readFromFile <= fileReadByBus;
			regReadData  <= bus.read ? next_regReadData : ZERO_BYTE;
		end
	end

	// both sources are flops, the mux picks one of them, or zero when no read is pending
	assign busReadData = !readPending ? ZERO_BYTE :
	                     readFromFile ? memBusData : regReadData;

endmodule

// ===== tb/cie_core_monitor.sv
// assertion checker for the instruction execution core
`timescale 1ns/100ps
module cie_core_monitor
	import cie_pkg::*;
(
	input wire logic                    sys_clk,
	input wire logic                    reset,
	input wire cie_instr_type           instr,
	input wire logic                    instrValid,
	input wire logic                    instrReady,
	input wire logic                    instrDone,
	input wire logic                    nopCycle,
	input wire logic                    busWrite,
	input wire logic [PC_W-1:0]         programCounter,
	input wire logic [DATA_W-1:0]       accumulator,
	input wire logic                    zeroFlag,
	input wire logic                    expiryStatus,
	input wire logic                    sleepStatus,
	input wire logic [WDOG_COUNT_W-1:0] watchdogCount,
	input wire logic [PC_W-1:0]         stackTop
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	// ****************************************
	// assertions
	// ****************************************
	// a bus write in the execute cycle may stall the op, so those cases are left out
	sequence take(cie_opcode_type op);
		instrValid && instrReady && instr.opcode == op;
	endsequence
	sequence run(cie_opcode_type op);
		take(op) ##1 !busWrite;
	endsequence

	AST_CALL_PC: assert property (take(OP_CALL) |-> ##2
		programCounter[LIT_W-1:0] == $past(instr.literal, 2)) else $error("call target wrong");
	AST_CALL_PUSH: assert property (take(OP_CALL) |-> ##2
		stackTop == $past(programCounter, 2) + PC_ONE) else $error("return address wrong");
	AST_CALL_NOP: assert property (take(OP_CALL) |=>
		!nopCycle ##1 nopCycle ##1 (instrReady && instrDone)) else $error("call not two cycles");
	AST_CALL_FLAGS: assert property (take(OP_CALL) |=> $stable(zeroFlag) [*3])
		else $error("call changed zero flag");
	AST_SKIP_FLAGS: assert property (take(OP_BIT_TEST_SKIP_IF_SET) |=> $stable(zeroFlag) [*2])
		else $error("skip changed zero flag");
	AST_SKIP_NOP: assert property (take(OP_BIT_TEST_SKIP_IF_SET) ##2 nopCycle |=>
		instrDone && programCounter == $past(programCounter) + PC_ONE) else $error("skip word kept");
	AST_CLRACC: assert property (run(OP_CLEAR_ACCUMULATOR) |=>
		accumulator == ZERO_BYTE && zeroFlag) else $error("accumulator clear wrong");
	AST_WDCLR: assert property (run(OP_WATCHDOG_CLEAR) |=>
		watchdogCount == ZERO_BYTE && expiryStatus && sleepStatus) else $error("watchdog clear wrong");
	AST_CLRREG: assert property (run(OP_CLEAR_REG) |=> zeroFlag && instrDone)
		else $error("register clear flag wrong");
	AST_ZERO_RES: assert property (instrValid && instrReady && instr.dest == DEST_ACCUM &&
		(instr.opcode == OP_COMPLEMENT_REG || instr.opcode == OP_DECREMENT_REG) ##1 !busWrite
		|=> instrDone && zeroFlag == (accumulator == ZERO_BYTE)) else $error("zero flag wrong");

	COV_CALL: cover property (take(OP_CALL));
	COV_SKIP: cover property (take(OP_BIT_TEST_SKIP_IF_SET) ##2 nopCycle);
	COV_WDCLR: cover property (run(OP_WATCHDOG_CLEAR));
endmodule

bind cie_core cie_core_monitor mon_u (.sys_clk, .reset, .instr, .instrValid, .instrReady,
	.instrDone, .nopCycle, .busWrite, .programCounter, .accumulator, .zeroFlag,
	.expiryStatus, .sleepStatus, .watchdogCount, .stackTop);

// ===== tb/cie_core_test.sv
// self-checking bench for the instruction execution core
`timescale 1ns/100ps
module cie_core_test
	import cie_pkg::*;
;
	logic                    sys_clk, reset, instrValid, instrReady, instrDone, nopCycle;
	logic                    sleepEnter, busWrite, busRead, zeroFlag, expiryStatus, sleepStatus;
	cie_instr_type           instr;
	logic [BUS_ADDR_W-1:0]   busAddr;
	logic [DATA_W-1:0]       busWriteData, busReadData, accumulator, rd;
	logic [WDOG_COUNT_W-1:0] watchdogCount;
	logic [PC_W-1:0]         programCounter, stackTop, pc;
	logic [PAGE_W-1:0]       pg [2] = '{5'h18, 5'h0F};
	logic [LIT_W-1:0]        lt [2] = '{11'h7FF, 11'h001};
	logic [DATA_W-1:0]       pat = 8'hA5;
	logic                    z;
	int                      err_total, compares, i;

	cie_core dut_u (.sys_clk, .reset, .instr, .instrValid, .instrReady, .instrDone, .nopCycle,
		.sleepEnter, .busAddr, .busWriteData, .busWrite, .busRead, .busReadData,
		.programCounter, .accumulator, .zeroFlag, .expiryStatus, .sleepStatus,
		.watchdogCount, .stackTop);

	initial begin
		sys_clk = 1'h0;
		forever #20 sys_clk = ~sys_clk;
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic close_out();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk_val(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_val(PC_W'(got), PC_W'(exp));
	endtask

	task automatic bus_wr(input logic [BUS_ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge sys_clk);
		busAddr <= a;
		busWriteData <= d;
		busWrite <= 1'h1;
		@(posedge sys_clk);
		busWrite <= 1'h0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [BUS_ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge sys_clk);
		busAddr <= a;
		busRead <= 1'h1;
		@(posedge sys_clk);
		busRead <= 1'h0;
		#1;
		d = busReadData;
	endtask

	// counts cycles from the accepting edge to the done pulse
	task automatic exec(input cie_opcode_type op, input logic [FILE_ADDR_W-1:0] fa,
		input logic [BIT_SEL_W-1:0] bs, input logic d, input logic [LIT_W-1:0] lit, input int cyc);
		int n;
		@(posedge sys_clk);
		instr <= '{op, fa, bs, d, lit};
		instrValid <= 1'h1;
		@(posedge sys_clk);
		instrValid <= 1'h0;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (instrDone !== 1'h1 && n < 8);
		if (instrDone !== 1'h1) begin
			err_total++;
			close_out();
		end else begin
			chk_val(PC_W'(n), PC_W'(cyc));
		end
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		reset = 1'h1;
		instrValid = 1'h0;
		instr = '0;
		sleepEnter = 1'h0;
		busWrite = 1'h0;
		busRead = 1'h0;
		busAddr = '0;
		busWriteData = '0;
		err_total = 0;
		compares = 0;
		repeat (8) @(posedge sys_clk);
		reset <= 1'h0;
		pc = PC_RESET;
		bus_wr(8'h10, 8'h5A);
		bus_wr(8'h11, 8'hFF);
		bus_wr(8'h12, 8'h01);
		bus_wr(8'h7F, pat);
		exec(OP_COMPLEMENT_REG, 7'h10, 3'h0, 1'h1, 11'h0, 1);
		bus_rd(8'h10, rd);
		chk_val(PC_W'(rd), 13'h00A5);
		chk_bit(zeroFlag, 1'h0);
		exec(OP_COMPLEMENT_REG, 7'h11, 3'h0, 1'h0, 11'h0, 1);
		chk_val(PC_W'(accumulator), 13'h0000);
		chk_bit(zeroFlag, 1'h1);
		bus_rd(8'h11, rd);
		chk_val(PC_W'(rd), 13'h00FF);
		exec(OP_DECREMENT_REG, 7'h12, 3'h0, 1'h1, 11'h0, 1);
		bus_rd(8'h12, rd);
		chk_val(PC_W'(rd), 13'h0000);
		chk_bit(zeroFlag, 1'h1);
		exec(OP_DECREMENT_REG, 7'h12, 3'h0, 1'h0, 11'h0, 1);
		chk_val(PC_W'(accumulator), 13'h00FF);
		chk_bit(zeroFlag, 1'h0);
		bus_wr(8'h13, 8'h77);
		exec(OP_CLEAR_REG, 7'h13, 3'h0, 1'h0, 11'h0, 1);
		bus_rd(8'h13, rd);
		chk_val(PC_W'(rd), 13'h0000);
		chk_bit(zeroFlag, 1'h1);
		bus_wr(OFS_ACCUM, 8'h33);
		bus_wr(OFS_STATUS, 8'h00);
		exec(OP_CLEAR_ACCUMULATOR, 7'h00, 3'h0, 1'h0, 11'h0, 1);
		chk_val(PC_W'(accumulator), 13'h0000);
		chk_bit(zeroFlag, 1'h1);
		pc = pc + 13'h0006;
		// every bit select, with the zero flag toggled so a stray update shows
		for (i = 0; i < 8; i++) begin
			bus_wr(OFS_STATUS, {7'h00, i[0]});
			exec(OP_BIT_TEST_SKIP_IF_SET, 7'h7F, i[2:0], 1'h0, 11'h0, 1 + pat[i]);
			pc = pc + 13'h0001 + PC_W'(pat[i]);
			chk_val(programCounter, pc);
			chk_bit(zeroFlag, i[0]);
		end
		for (i = 0; i < 2; i++) begin
			bus_wr(OFS_PAGE, {3'h0, pg[i]});
			z = zeroFlag;
			exec(OP_CALL, 7'h55, 3'h5, 1'h1, lt[i], 2);
			chk_val(stackTop, pc + PC_ONE);
			pc = {pg[i][PAGE_SEL_HI:PAGE_SEL_LO], lt[i]};
			chk_val(programCounter, pc);
			chk_bit(zeroFlag, z);
		end
		// the first timeout needs both eight-bit counters run full, so expiry must fall
		i = 0;
		while (expiryStatus !== 1'h0 && i < 70000) begin
			@(posedge sys_clk);
			#1;
			i++;
		end
		if (expiryStatus !== 1'h0) begin
			err_total++;
			close_out();
		end else begin
			chk_bit(expiryStatus, 1'h0);
		end
		// both counters restart at zero, one prescaler round later the counter reads one
		repeat (300) @(posedge sys_clk);
		#1;
		chk_val(PC_W'(watchdogCount), 13'h0001);
		@(posedge sys_clk);
		sleepEnter <= 1'h1;
		@(posedge sys_clk);
		sleepEnter <= 1'h0;
		#1;
		chk_bit(sleepStatus, 1'h0);
		exec(OP_WATCHDOG_CLEAR, 7'h00, 3'h0, 1'h0, 11'h0, 1);
		chk_val(PC_W'(watchdogCount), 13'h0000);
		chk_bit(expiryStatus, 1'h1);
		chk_bit(sleepStatus, 1'h1);
		// a prescaler left running would tick the counter before this point
		repeat (250) @(posedge sys_clk);
		#1;
		chk_val(PC_W'(watchdogCount), 13'h0000);
		bus_rd(8'h90, rd);
		chk_val(PC_W'(rd), 13'h0000);
		close_out();
	end
endmodule
